//--- logic/mid_core.sv
// module: instruction sequencer, file access and status of the midrange core
`timescale 1ns/1ps
`default_nettype none
module mid_core
    import mid_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    output logic [mid_pkg::MID_PCW-1:0] prog_addr,
    input wire logic [mid_pkg::MID_IW-1:0] instr_word,
    output logic [mid_pkg::MID_FAW-1:0] file_addr,
    output logic file_rd,
    output logic file_wr,
    output logic [mid_pkg::MID_DW-1:0] file_wdata,
    input wire logic [mid_pkg::MID_DW-1:0] file_rdata,
    input wire logic [mid_pkg::MID_DW-1:0] port_pins,
    input wire logic prescaler_to_timer,
    output logic prescaler_clear,
    input wire logic [mid_pkg::MID_PCW-1:0] ret_addr,
    output logic stack_push,
    output logic stack_pop,
    output logic [mid_pkg::MID_PCW-1:0] push_addr,
    output logic interrupt_ret,
    output logic [mid_pkg::MID_DW-1:0] acc,
    output logic carry_flag,
    output logic digit_carry_flag,
    output logic zero_flag,
    output logic timeout_flag,
    output logic powerdown_flag,
    output logic standby_req,
    output logic watchdog_kick,
    output logic instr_retire
);
    typedef struct packed {
        mid_phase_t phase;
        logic [MID_PCW-1:0] pc;
        logic [MID_IW-1:0] ir;
        logic ir_valid;
        logic [MID_DW-1:0] pins_meta;
        logic [MID_DW-1:0] pins_sync;
        logic [MID_DW-1:0] opnd;
        logic [MID_DW-1:0] acc;
        logic c;
        logic dc;
        logic z;
        logic to;
        logic pd;
        logic [MID_FAW-1:0] faddr;
        logic frd;
        logic fwr;
        logic [MID_DW-1:0] fwdata;
        logic psc_clr;
        logic push;
        logic pop;
        logic iret;
        logic [MID_PCW-1:0] push_addr;
        logic standby;
        logic kick;
        logic retire;
    } mid_core_st_t;

    mid_core_st_t q;
    mid_core_st_t d;
    mid_dec_t dec;
    mid_alu_t alu;
    logic ex;
    logic skip_now;
    logic [MID_PCW-1:0] jump_target;

    ////////////////////////////////////////////////////////////////////////////
    // decode and data path on the held word

    mid_decode u_decode (
        .instr (q.ir),
        .dec   (dec)
    );

    mid_alu u_alu (
        .dec   (dec),
        .opnd  (q.opnd),
        .acc   (q.acc),
        .carry (q.c),
        .r     (alu)
    );

    assign ex = (q.phase == ph_execute) && q.ir_valid;
    assign jump_target = {q.pc[MID_PCW-1:MID_K11W], dec.k11};

    always_comb
    begin
        case (dec.op)
            op_dec_skip_zero, op_inc_skip_zero: skip_now = alu.z;
            op_test_skip_clear: skip_now = !alu.bit_val;
            op_test_skip_set: skip_now = alu.bit_val;
            default: skip_now = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        d = q;
        d.pins_meta = port_pins;
        d.pins_sync = q.pins_meta;
        d.frd = 1'b0;
        d.fwr = 1'b0;
        d.psc_clr = 1'b0;
        d.push = 1'b0;
        d.pop = 1'b0;
        d.iret = 1'b0;
        d.standby = 1'b0;
        d.kick = 1'b0;
        d.retire = 1'b0;
        case (q.phase)
            ph_setup:
            begin
                d.phase = ph_read;
                if (q.ir_valid && dec.names_file)
                begin
                    d.faddr = dec.fa;
                    d.frd = 1'b1;
                end
            end
            ph_read:
            begin
                d.phase = ph_capture;
            end
            ph_capture:
            begin
                d.phase = ph_execute;
                if (q.faddr == MID_PORT_ADDR)
                    d.opnd = q.pins_sync;
                else
                    d.opnd = file_rdata;
            end
            ph_execute:
            begin
                d.phase = ph_setup;
                d.ir = instr_word;
                d.ir_valid = 1'b1;
                d.pc = q.pc + MID_PC_STEP;
                if (q.ir_valid)
                begin
                    d.retire = 1'b1;
                    if (dec.wr_file)
                    begin
                        d.fwr = 1'b1;
                        d.fwdata = alu.res;
                        if (dec.fa == MID_TIMER_ZERO_ADDR && prescaler_to_timer)
                            d.psc_clr = 1'b1;
                    end
                    if (dec.wr_acc)
                        d.acc = alu.res;
                    if (dec.upd_c)
                        d.c = alu.c;
                    if (dec.upd_dc)
                        d.dc = alu.dc;
                    if (dec.upd_z)
                        d.z = alu.z;
                    if (dec.skip_kind && skip_now)
                        d.ir_valid = 1'b0;
                    if (dec.two_cycle)
                        d.ir_valid = 1'b0;
                    case (dec.op)
                        op_call:
                        begin
                            d.push = 1'b1;
                            d.push_addr = q.pc;
                            d.pc = jump_target;
                        end
                        op_branch_jump:
                        begin
                            d.pc = jump_target;
                        end
                        op_return, op_return_literal, op_interrupt_return:
                        begin
                            d.pop = 1'b1;
                            d.iret = (dec.op == op_interrupt_return);
                            d.pc = ret_addr;
                        end
                        op_standby:
                        begin
                            d.standby = 1'b1;
                            d.pd = 1'b0;
                            d.to = 1'b1;
                        end
                        op_watchdog_kick:
                        begin
                            d.kick = 1'b1;
                            d.pd = 1'b1;
                            d.to = 1'b1;
                        end
                        default:
                        begin
                        end
                    endcase
                end
            end
            default:
            begin
                d.phase = ph_setup;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            q <= '0;
            q.phase <= ph_setup;
            q.pc <= MID_RESET_VEC;
            q.to <= 1'b1;
            q.pd <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign prog_addr = q.pc;
    assign file_addr = q.faddr;
    assign file_rd = q.frd;
    assign file_wr = q.fwr;
    assign file_wdata = q.fwdata;
    assign prescaler_clear = q.psc_clr;
    assign stack_push = q.push;
    assign stack_pop = q.pop;
    assign push_addr = q.push_addr;
    assign interrupt_ret = q.iret;
    assign acc = q.acc;
    assign carry_flag = q.c;
    assign digit_carry_flag = q.dc;
    assign zero_flag = q.z;
    assign timeout_flag = q.to;
    assign powerdown_flag = q.pd;
    assign standby_req = q.standby;
    assign watchdog_kick = q.kick;
    assign instr_retire = q.retire;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_phase_cycle;
        q.phase == ph_execute |=> q.phase == ph_setup ##1 q.phase == ph_read
            ##1 q.phase == ph_capture ##1 q.phase == ph_execute;
    endproperty
    a_phase_cycle: assert property (p_phase_cycle)
        else $error("instruction cycle is not four periods");

    property p_read_before_write;
        file_wr |-> $past(file_rd, 3) && $past(file_addr, 3) == file_addr;
    endproperty
    a_read_before_write: assert property (p_read_before_write)
        else $error("file store without prior read");

    property p_dest_acc;
        ex && dec.names_file && dec.upd_z && !dec.dst_file
            |=> !file_wr && acc == $past(alu.res);
    endproperty
    a_dest_acc: assert property (p_dest_acc)
        else $error("destination zero did not write accumulator");

    property p_dest_file;
        ex && dec.names_file && dec.upd_z && dec.dst_file
            |=> file_wr && file_wdata == $past(alu.res) && $stable(acc);
    endproperty
    a_dest_file: assert property (p_dest_file)
        else $error("destination one did not write file");

    property p_port_readback;
        q.phase == ph_capture && q.faddr == MID_PORT_ADDR |=> q.opnd == $past(q.pins_sync);
    endproperty
    a_port_readback: assert property (p_port_readback)
        else $error("port operand not taken from pins");

    property p_prescaler;
        prescaler_clear |-> file_wr && file_addr == MID_TIMER_ZERO_ADDR
            && $past(prescaler_to_timer);
    endproperty
    a_prescaler: assert property (p_prescaler)
        else $error("prescaler clear without timer store");

    property p_jump_flush;
        ex && dec.two_cycle |=> !q.ir_valid ##4 q.ir_valid;
    endproperty
    a_jump_flush: assert property (p_jump_flush)
        else $error("jump did not insert one empty cycle");

    property p_skip_zero;
        ex && dec.op inside {op_dec_skip_zero, op_inc_skip_zero} && alu.z
            |=> !q.ir_valid && $stable({carry_flag, digit_carry_flag, zero_flag});
    endproperty
    a_skip_zero: assert property (p_skip_zero)
        else $error("zero result did not skip or touched status");

    property p_test_set;
        ex && dec.op == op_test_skip_set |=> q.ir_valid == !$past(alu.bit_val);
    endproperty
    a_test_set: assert property (p_test_set)
        else $error("skip on set bit wrong");

    property p_rotate_flags;
        ex && dec.op inside {op_rotate_left_carry, op_rotate_right_carry}
            |=> $stable(zero_flag) && $stable(digit_carry_flag) && carry_flag == $past(alu.c);
    endproperty
    a_rotate_flags: assert property (p_rotate_flags)
        else $error("rotate touched flags other than carry");

    property p_logic_flags;
        ex && dec.op inside {op_and_acc_file, op_or_acc_file, op_xor_acc_file, op_and_literal}
            |=> $stable(carry_flag) && $stable(digit_carry_flag) && zero_flag == $past(alu.z);
    endproperty
    a_logic_flags: assert property (p_logic_flags)
        else $error("logic op flags wrong");

    property p_standby;
        ex && dec.op == op_standby |=> standby_req && !powerdown_flag && timeout_flag
            && q.ir_valid;
    endproperty
    a_standby: assert property (p_standby)
        else $error("standby flags wrong");

    property p_return;
        ex && dec.op inside {op_return, op_interrupt_return}
            |=> stack_pop && prog_addr == $past(ret_addr) && $stable(zero_flag);
    endproperty
    a_return: assert property (p_return)
        else $error("return did not load return address");

    property p_nop_dontcare;
        q.ir ==? 14'b00_0000_0??0_0000 |-> dec.op == op_no_operation && !dec.names_file;
    endproperty
    a_nop_dontcare: assert property (p_nop_dontcare)
        else $error("no-operation word decoded wrongly");
endmodule
`default_nettype wire

//--- logic/mid_pkg.sv
// package: widths, constants, op codes and carriers of the midrange decoder
// Overview of operation
// - take 14-bit words: opcode plus operand fields
// - destination bit 0 to accumulator, 1 to file
// - file operand is 7-bit address, 0x00-0x7F
// - 8-bit data literals, 11-bit jump targets
// - bit field picks one bit of file
// - instruction cycle is four clock periods
// - true conditional test adds one no-operation cycle
// - program counter changes take two cycles
// - file instructions read, modify, then store
// - port readback uses pin levels, not latch
// - store to timer count clears assigned prescaler
// - dec/inc skip if zero, status untouched
// - rotates through carry update only carry
// - file logic ops update zero; add/sub all
// - bit op code: clear, set, skip-clear, skip-set
// - literal arithmetic and logic ops with their flags
// - standby sets timeout and clears powerdown; watchdog kick sets both flags
// - interrupt return and plain return take two cycles
// - don't-care encoding bits are ignored
package mid_pkg;
    localparam int MID_IW = 14;
    localparam int MID_PCW = 13;
    localparam int MID_FAW = 7;
    localparam int MID_DW = 8;
    localparam int MID_K11W = 11;
    localparam int MID_BSW = 3;
    localparam int MID_D_POS = 7;
    localparam int MID_B_LSB = 7;
    localparam int MID_NIB = 4;
    localparam logic [MID_PCW-1:0] MID_RESET_VEC = 13'h0000;
    localparam logic [MID_PCW-1:0] MID_PC_STEP = 13'h0001;
    localparam logic [MID_FAW-1:0] MID_PORT_ADDR = 7'h05;
    localparam logic [MID_FAW-1:0] MID_TIMER_ZERO_ADDR = 7'h01;
    localparam logic [MID_DW-1:0] MID_ZERO = 8'h00;
    localparam logic [MID_DW-1:0] MID_ONE = 8'h01;

    typedef enum logic [5:0] {
        op_no_operation, op_move_acc_file, op_clear_acc, op_clear_file,
        op_sub_acc_from_file, op_dec_file, op_or_acc_file, op_and_acc_file,
        op_xor_acc_file, op_add_acc_to_file, op_move_file, op_compl_file,
        op_inc_file, op_dec_skip_zero, op_rotate_right_carry, op_rotate_left_carry,
        op_swap_file, op_inc_skip_zero, op_bit_clear, op_bit_set,
        op_test_skip_clear, op_test_skip_set, op_call, op_branch_jump,
        op_move_literal, op_return_literal, op_or_literal, op_and_literal,
        op_xor_literal, op_sub_from_literal, op_add_literal, op_return,
        op_interrupt_return, op_standby, op_watchdog_kick
    } mid_op_t;

    typedef enum logic [1:0] {ph_setup, ph_read, ph_capture, ph_execute} mid_phase_t;

    typedef struct packed {
        mid_op_t op;
        logic [MID_FAW-1:0] fa;
        logic dst_file;
        logic [MID_BSW-1:0] bsel;
        logic [MID_DW-1:0] k8;
        logic [MID_K11W-1:0] k11;
        logic names_file;
        logic wr_file;
        logic wr_acc;
        logic upd_c;
        logic upd_dc;
        logic upd_z;
        logic two_cycle;
        logic skip_kind;
    } mid_dec_t;

    typedef struct packed {
        logic [MID_DW-1:0] res;
        logic c;
        logic dc;
        logic z;
        logic bit_val;
    } mid_alu_t;
endpackage

//--- logic/mid_decode.sv
// module: instruction word decoder
`timescale 1ns/1ps
`default_nettype none
module mid_decode
    import mid_pkg::*;
(
    input wire logic [mid_pkg::MID_IW-1:0] instr,
    output var mid_pkg::mid_dec_t dec
);
    logic byte_op;

    always_comb
    begin
        dec = '0;
        dec.fa = instr[MID_FAW-1:0];
        dec.dst_file = instr[MID_D_POS];
        dec.bsel = instr[MID_B_LSB +: MID_BSW];
        dec.k8 = instr[MID_DW-1:0];
        dec.k11 = instr[MID_K11W-1:0];
        // ? bits are don't-care; unlisted words run as no-operation
        casez (instr)
            14'b00_0000_0??0_0000: dec.op = op_no_operation;
            14'b00_0000_0000_1001: dec.op = op_interrupt_return;
            14'b00_0000_0000_1000: dec.op = op_return;
            14'b00_0000_0110_0011: dec.op = op_standby;
            14'b00_0000_0110_0100: dec.op = op_watchdog_kick;
            14'b00_0000_1???_????: dec.op = op_move_acc_file;
            14'b00_0001_0???_????: dec.op = op_clear_acc;
            14'b00_0001_1???_????: dec.op = op_clear_file;
            14'b00_0010_????_????: dec.op = op_sub_acc_from_file;
            14'b00_0011_????_????: dec.op = op_dec_file;
            14'b00_0100_????_????: dec.op = op_or_acc_file;
            14'b00_0101_????_????: dec.op = op_and_acc_file;
            14'b00_0110_????_????: dec.op = op_xor_acc_file;
            14'b00_0111_????_????: dec.op = op_add_acc_to_file;
            14'b00_1000_????_????: dec.op = op_move_file;
            14'b00_1001_????_????: dec.op = op_compl_file;
            14'b00_1010_????_????: dec.op = op_inc_file;
            14'b00_1011_????_????: dec.op = op_dec_skip_zero;
            14'b00_1100_????_????: dec.op = op_rotate_right_carry;
            14'b00_1101_????_????: dec.op = op_rotate_left_carry;
            14'b00_1110_????_????: dec.op = op_swap_file;
            14'b00_1111_????_????: dec.op = op_inc_skip_zero;
            14'b01_00??_????_????: dec.op = op_bit_clear;
            14'b01_01??_????_????: dec.op = op_bit_set;
            14'b01_10??_????_????: dec.op = op_test_skip_clear;
            14'b01_11??_????_????: dec.op = op_test_skip_set;
            14'b10_0???_????_????: dec.op = op_call;
            14'b10_1???_????_????: dec.op = op_branch_jump;
            14'b11_00??_????_????: dec.op = op_move_literal;
            14'b11_01??_????_????: dec.op = op_return_literal;
            14'b11_1000_????_????: dec.op = op_or_literal;
            14'b11_1001_????_????: dec.op = op_and_literal;
            14'b11_1010_????_????: dec.op = op_xor_literal;
            14'b11_110?_????_????: dec.op = op_sub_from_literal;
            14'b11_111?_????_????: dec.op = op_add_literal;
            default: dec.op = op_no_operation;
        endcase
        byte_op = dec.op inside {[op_move_acc_file:op_inc_skip_zero]} && dec.op != op_clear_acc;
        dec.names_file = byte_op || dec.op inside {[op_bit_clear:op_test_skip_set]};
        dec.wr_file = (byte_op && dec.dst_file) || dec.op inside {op_bit_clear, op_bit_set};
        dec.wr_acc = (byte_op && !dec.dst_file && dec.op != op_move_acc_file)
            || dec.op inside {op_clear_acc, [op_move_literal:op_add_literal]};
        dec.upd_c = dec.op inside {op_add_acc_to_file, op_sub_acc_from_file,
            op_rotate_left_carry, op_rotate_right_carry, op_add_literal, op_sub_from_literal};
        dec.upd_dc = dec.op inside {op_add_acc_to_file, op_sub_acc_from_file,
            op_add_literal, op_sub_from_literal};
        dec.upd_z = dec.op inside {op_add_acc_to_file, op_sub_acc_from_file, op_and_acc_file,
            op_or_acc_file, op_xor_acc_file, op_clear_file, op_clear_acc, op_compl_file,
            op_dec_file, op_inc_file, op_move_file, [op_or_literal:op_add_literal]};
        dec.two_cycle = dec.op inside {op_call, op_branch_jump, op_return_literal,
            op_return, op_interrupt_return};
        dec.skip_kind = dec.op inside {op_dec_skip_zero, op_inc_skip_zero,
            op_test_skip_clear, op_test_skip_set};
    end
endmodule
`default_nettype wire

//--- logic/mid_alu.sv
// module: data path arithmetic and logic for one instruction
`timescale 1ns/1ps
`default_nettype none
module mid_alu
    import mid_pkg::*;
(
    input wire mid_pkg::mid_dec_t dec,
    input wire logic [mid_pkg::MID_DW-1:0] opnd,
    input wire logic [mid_pkg::MID_DW-1:0] acc,
    input wire logic carry,
    output var mid_pkg::mid_alu_t r
);
    logic [MID_DW-1:0] x;
    logic [MID_DW-1:0] yy;
    logic [MID_DW-1:0] mask;
    logic inv;
    logic [MID_DW:0] s9;
    logic [MID_NIB:0] s5;

    always_comb
    begin
        x = opnd;
        inv = dec.op inside {op_sub_acc_from_file, op_sub_from_literal};
        if (dec.op inside {op_add_literal, op_sub_from_literal})
            x = dec.k8;
        yy = inv ? ~acc : acc;
        s9 = {1'b0, x} + {1'b0, yy} + {{MID_DW{1'b0}}, inv};
        s5 = {1'b0, x[MID_NIB-1:0]} + {1'b0, yy[MID_NIB-1:0]} + {{MID_NIB{1'b0}}, inv};
        mask = MID_ONE << dec.bsel;
        r.c = carry;
        r.dc = s5[MID_NIB];
        r.bit_val = opnd[dec.bsel];
        case (dec.op)
            op_move_acc_file: r.res = acc;
            op_clear_acc, op_clear_file: r.res = MID_ZERO;
            op_add_acc_to_file, op_sub_acc_from_file, op_add_literal, op_sub_from_literal:
            begin
                r.res = s9[MID_DW-1:0];
                r.c = s9[MID_DW];
            end
            op_dec_file, op_dec_skip_zero: r.res = opnd - MID_ONE;
            op_inc_file, op_inc_skip_zero: r.res = opnd + MID_ONE;
            op_or_acc_file: r.res = acc | opnd;
            op_and_acc_file: r.res = acc & opnd;
            op_xor_acc_file: r.res = acc ^ opnd;
            op_compl_file: r.res = ~opnd;
            op_rotate_left_carry:
            begin
                r.res = {opnd[MID_DW-2:0], carry};
                r.c = opnd[MID_DW-1];
            end
            op_rotate_right_carry:
            begin
                r.res = {carry, opnd[MID_DW-1:1]};
                r.c = opnd[0];
            end
            op_swap_file: r.res = {opnd[MID_NIB-1:0], opnd[MID_DW-1:MID_NIB]};
            op_bit_clear: r.res = opnd & ~mask;
            op_bit_set: r.res = opnd | mask;
            op_move_literal, op_return_literal: r.res = dec.k8;
            op_or_literal: r.res = acc | dec.k8;
            op_and_literal: r.res = acc & dec.k8;
            op_xor_literal: r.res = acc ^ dec.k8;
            default: r.res = opnd;
        endcase
        r.z = (r.res == MID_ZERO);
    end
endmodule
`default_nettype wire

//--- dv/mid_core_bench.sv
// testbench: program and file model driving the midrange core
`timescale 1ns/1ps
`default_nettype none
module mid_core_bench;
    import mid_pkg::*;
    logic clk_sys, rst, file_rd, file_wr, prescaler_to_timer, prescaler_clear;
    logic carry_flag, digit_carry_flag, zero_flag, timeout_flag, powerdown_flag;
    logic watchdog_kick, instr_retire, stack_push, stack_pop, interrupt_ret, standby_req;
    logic [MID_PCW-1:0] prog_addr, ret_addr, push_addr;
    logic [MID_IW-1:0] instr_word;
    logic [MID_FAW-1:0] file_addr;
    logic [MID_DW-1:0] file_wdata, file_rdata, port_pins, acc;
    logic [MID_IW-1:0] mem [0:31];
    logic [MID_DW-1:0] fm [0:127];
    logic [10:0] snap [0:31];
    logic [10:0] row_exp [0:15];
    logic [1:0] pd_seen;
    int err_count = 0, cmp_count = 0, cyc = 0, rd_n = 0, wr_n = 0, clr_n = 0, ret_n = 0;
    int t_first = 0, t_kick = 0, iret_n = 0;
    mid_core dut_u (.clk_sys(clk_sys), .rst(rst), .prog_addr(prog_addr),
        .instr_word(instr_word), .file_addr(file_addr), .file_rd(file_rd), .file_wr(file_wr),
        .file_wdata(file_wdata), .file_rdata(file_rdata), .port_pins(port_pins),
        .prescaler_to_timer(prescaler_to_timer), .prescaler_clear(prescaler_clear),
        .ret_addr(ret_addr), .stack_push(stack_push), .stack_pop(stack_pop),
        .push_addr(push_addr), .interrupt_ret(interrupt_ret),
        .acc(acc), .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag),
        .zero_flag(zero_flag), .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag),
        .standby_req(standby_req), .watchdog_kick(watchdog_kick), .instr_retire(instr_retire));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("counts: %0d compares, %0d mismatches", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // program memory and file space models
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        instr_word <= mem[prog_addr[4:0]];
        if (rst)
        begin
            file_rdata <= '0;
            ret_addr <= '0;
            fm[7'h20] <= 8'h11;
            fm[7'h21] <= 8'h01;
            fm[7'h22] <= 8'h81;
            fm[7'h01] <= 8'h00;
            fm[7'h05] <= 8'hff;
        end
        if (file_rd) file_rdata <= fm[file_addr];
        if (file_rd) rd_n <= rd_n + 1;
        if (file_wr) fm[file_addr] <= file_wdata;
        if (file_wr) wr_n <= wr_n + 1;
        if (prescaler_clear) clr_n <= clr_n + 1;
        if (instr_retire) snap[ret_n[4:0]] <= {acc, carry_flag, digit_carry_flag, zero_flag};
        if (instr_retire) ret_n <= ret_n + 1;
        if (instr_retire && ret_n == 0) t_first <= cyc;
        if (watchdog_kick) t_kick <= cyc;
        if (stack_push) ret_addr <= push_addr;
        if (stack_pop && interrupt_ret) iret_n <= iret_n + 1;
        if (standby_req) pd_seen <= {timeout_flag, powerdown_flag};
        if (cyc == 400)
        begin
            err_count++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        mem = '{14'h383a, 14'h390f, 14'h3ff7, 14'h0ba1, 14'h38ff, 14'h07a0, 14'h1581,
            14'h0485, 14'h280c, 14'h38ff, 14'h38ff, 14'h38ff, 14'h0060, 14'h2010,
            14'h0064, 14'h280f, 14'h0c22, 14'h1fa2, 14'h38ff, 14'h0622, 14'h0063,
            14'h0009, 14'h0000, 14'h0000, 14'h0000, 14'h0000, 14'h0000, 14'h0000,
            14'h0000, 14'h0000, 14'h0000, 14'h0000};
        row_exp = '{11'h1d0, 11'h050, 11'h00e, 11'h00e, 11'h008, 11'h008, 11'h008,
            11'h008, 11'h008, 11'h008, 11'h204, 11'h204, 11'h60c, 11'h60c, 11'h60c, 11'h60c};
        rst = 1'b1;
        port_pins = 8'h5a;
        prescaler_to_timer = 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        while (t_kick == 0) @(posedge clk_sys);
        for (int i = 0; i < 16; i++)
            chk({5'h0, snap[i]}, {5'h0, row_exp[i]});
        $display("test flags and accumulator done");
        chk(16'(fm[7'h20]), 16'h0012);
        chk(16'(fm[7'h21]), 16'h0000);
        chk(16'(fm[7'h22]), 16'h0081);
        chk(16'(fm[7'h01]), 16'h0008);
        chk(16'(fm[7'h05]), 16'h005b);
        chk(16'(clr_n), 16'h0001);
        chk(16'(rd_n), 16'h0007);
        chk(16'(wr_n), 16'h0004);
        $display("test file access done");
        chk(16'(ret_n), 16'h0010);
        chk(16'(t_kick - t_first), 16'h0050);
        chk(16'(iret_n), 16'h0001);
        chk({14'h0, pd_seen}, 16'h0002);
        chk({14'h0, timeout_flag, powerdown_flag}, 16'h0003);
        $display("test sequencing done");
        close_out();
    end
endmodule
`default_nettype wire
